// file: core/noa_cfg.svh
// register offsets, field positions, reset values and counts of the oscillator block
`ifndef NOA_CFG_SVH
`define NOA_CFG_SVH

// ------------------------------------------------------------
// register byte offsets on the apb bus
// ------------------------------------------------------------
`define NOA_OFS_CTRL 8'h00
`define NOA_OFS_CLK 8'h04
`define NOA_OFS_ACCL 8'h08
`define NOA_OFS_ACCH 8'h0C
`define NOA_OFS_ACCU 8'h10
`define NOA_OFS_INCL 8'h14
`define NOA_OFS_INCH 8'h18
`define NOA_OFS_INCU 8'h1C
`define NOA_OFS_FLAG 8'h20

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define NOA_CTRL_EN 7
`define NOA_CTRL_OUT 5
`define NOA_CTRL_POL 4
`define NOA_CTRL_PFM 0
`define NOA_CLK_PWS_LO 5
`define NOA_CLK_CKS_LO 0
`define NOA_FLAG_IRQ 0

// ------------------------------------------------------------
// clock source codes, reset values and counts
// ------------------------------------------------------------
`define NOA_CKS_FAST 2'h0
`define NOA_CKS_SYSOSC 2'h1
`define NOA_CKS_LC1 2'h2
`define NOA_RST_VAL 32'h0000_0000
`define NOA_LOAD_EDGES 2'h2

`endif

// file: core/noa_pkg.sv
// types shared by the oscillator block and its output stage
package noa_pkg;

   // software control fields of the oscillator
   typedef struct packed {
      logic enable;
      logic polarity;
      logic pfm;
      logic [1:0] clk_sel;
      logic [2:0] pulse_width;
   } noa_ctrl_s;

   // apb request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } noa_apb_req_s;

   // apb answer of the slave
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } noa_apb_rsp_s;

endpackage

// file: core/noa_out_stage.sv
// output stage: toggle flip-flop, pulse stretcher and polarity
`timescale 1ns/1ps
`default_nettype none

module noa_out_stage (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // events from the accumulator
   input wire logic osc_edge_in,
   input wire logic carry_in,
   // control
   input wire noa_pkg::noa_ctrl_s ctrl_in,
   // output
   output logic osc_out_out
);
   import noa_pkg::*;

   typedef struct packed {
      logic toggle;
      logic active;
      logic pending;
      logic [7:0] count;
      logic final_out;
   } noa_stage_s;

   noa_stage_s state;
   noa_stage_s next_state;
   logic raw;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      if (!ctrl_in.enable) begin
         // a stopped oscillator parks its output inactive
         next_state.toggle = 1'b0;
         next_state.active = 1'b0;
         next_state.pending = 1'b0;
         next_state.count = 8'h00;
      end else if (osc_edge_in) begin
         if (carry_in) begin
            next_state.toggle = ~state.toggle;
         end
         if (state.pending) begin
            // pulse starts on the edge after the overflow
            next_state.active = 1'b1;
            next_state.count = 8'((9'h001 << ctrl_in.pulse_width) - 9'h001);
         end else if (state.active) begin
            if (state.count == 8'h00) begin
               next_state.active = 1'b0;
            end else begin
               next_state.count = state.count - 8'h01;
            end
         end
         next_state.pending = carry_in;
      end
      raw = ctrl_in.pfm ? next_state.active : next_state.toggle;
      next_state.final_out = raw ^ ctrl_in.polarity;
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign osc_out_out = state.final_out;

endmodule

`default_nettype wire

// file: core/noa_core.sv
// numerically controlled oscillator: accumulator, increment buffers and apb registers
//
// Operation
// - 20-bit accumulator, three readable writable bytes
// - each input clock edge adds increment
// - adder carry is the overflow event
// - each overflow also gives an interrupt event
// - two-bit select picks one of three clocks
// - 20-bit increment in low, high, upper bytes
// - increment readable; internal buffers hidden
// - enabled: low write loads buffers, second edge
// - disabled: buffers load immediately on write
// - fixed duty mode toggles output per overflow
// - mode bit clear selects fixed duty mode
// - stretcher or toggle feeds output
// - pulse mode: active N periods after overflow
// - polarity bit inverts final output
// - reset clears every register to zero
// - overflow sets flag; software clears it
//
// ------------------------------------------------------------
// register map, one byte register per 32-bit word
// ------------------------------------------------------------
// 00 control: [7] enable, [5] output level (read only),
//    [4] polarity, [0] pulse mode; other bits read zero
// 04 clock: [7:5] pulse width code, [1:0] clock select
//    (0 fast internal, 1 system osc, 2 logic cell, 3 none)
// 08, 0c, 10 accumulator low, high, upper (upper bits 3:0)
// 14, 18, 1c increment low, high, upper (upper bits 3:0)
// 20 flag: [0] overflow flag; writing zero clears it,
//    writing one leaves it alone
// any other offset answers with pslverr and reads zero
//
// ------------------------------------------------------------
// behaviour a user must know
// ------------------------------------------------------------
// - the three sources are sampled as levels on the core clock,
//   so each must stay high and low for at least one core cycle;
//   faster sources alias and lose edges
// - changing the clock select while running may fake one edge
// - with the block running, only a low increment write arms the
//   buffer transfer; high and upper writes wait for it, which
//   keeps a half-written increment out of the adder
// - a software accumulator write wins over a same-cycle addition
// - an overflow in the cycle of a flag clear keeps the flag set
// - disabling clears the toggle and pulse state, so the output
//   parks at its inactive level, set by the polarity bit
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none

`include "noa_cfg.svh"

module noa_core #(
   parameter int ACC_W = 20
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // apb slave
   input wire noa_pkg::noa_apb_req_s apb_req_in,
   output noa_pkg::noa_apb_rsp_s apb_rsp_out,
   // candidate oscillator clocks, synchronous levels
   input wire logic fast_internal_osc_in,
   input wire logic sys_osc_clk_in,
   input wire logic logic_cell_one_out_in,
   // oscillator results
   output logic osc_out_out,
   output logic osc_irq_event_out,
   output logic osc_irq_flag_out
);
   import noa_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      noa_ctrl_s ctrl;
      logic [ACC_W-1:0] accum;
      logic [ACC_W-1:0] inc_reg;
      logic [ACC_W-1:0] inc_buf;
      logic load_pend;
      logic [1:0] load_cnt;
      logic irq_flag;
      logic irq_pulse;
      logic clk_prev;
      logic [31:0] rdata;
   } noa_state_s;

   noa_state_s state;
   noa_state_s next_state;

   logic sel_clk;
   logic osc_edge;
   logic [ACC_W:0] sum;
   logic carry;
   logic setup;
   logic access;
   logic wr;
   logic mapped;
   logic out_level;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------

   // replace one byte of a wide register, dropping bits above the width
   function automatic logic [ACC_W-1:0] put_byte(input logic [ACC_W-1:0] val,
                                               input logic [1:0] idx,
                                               input logic [7:0] data);
      logic [23:0] wide;
      wide = 24'(val);
      wide[idx*8 +: 8] = data;
      return wide[ACC_W-1:0];
   endfunction

   // pick one byte of a wide register, zero above the width
   function automatic logic [31:0] get_byte(input logic [ACC_W-1:0] val,
                                            input logic [1:0] idx);
      logic [23:0] wide;
      wide = 24'(val);
      return {24'h00_0000, wide[idx*8 +: 8]};
   endfunction

   // true for every offset this slave answers
   function automatic logic is_mapped(input logic [7:0] addr);
      return (addr == `NOA_OFS_CTRL) || (addr == `NOA_OFS_CLK) ||
             (addr == `NOA_OFS_ACCL) || (addr == `NOA_OFS_ACCH) ||
             (addr == `NOA_OFS_ACCU) || (addr == `NOA_OFS_INCL) ||
             (addr == `NOA_OFS_INCH) || (addr == `NOA_OFS_INCU) ||
             (addr == `NOA_OFS_FLAG);
   endfunction

   // true for the three increment byte offsets
   function automatic logic is_inc_addr(input logic [7:0] addr);
      return (addr == `NOA_OFS_INCL) || (addr == `NOA_OFS_INCH) ||
             (addr == `NOA_OFS_INCU);
   endfunction

   // ------------------------------------------------------------
   // clock selection and edge detection
   // ------------------------------------------------------------

   // sources are sampled as plain levels; switching the select can fake one edge
   always_comb begin
      unique case (state.ctrl.clk_sel)
         `NOA_CKS_FAST: sel_clk = fast_internal_osc_in;
         `NOA_CKS_SYSOSC: sel_clk = sys_osc_clk_in;
         `NOA_CKS_LC1: sel_clk = logic_cell_one_out_in;
         default: sel_clk = 1'b0; // reserved code: no clock, block stalls
      endcase
   end

   assign osc_edge = sel_clk & ~state.clk_prev;

   // ------------------------------------------------------------
   // adder
   // ------------------------------------------------------------

   // full adder; the carry leaves the top and the residue stays behind
   assign sum = {1'b0, state.accum} + {1'b0, state.inc_buf};
   assign carry = state.ctrl.enable & osc_edge & sum[ACC_W];

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   assign setup = apb_req_in.psel & ~apb_req_in.penable;
   assign access = apb_req_in.psel & apb_req_in.penable;
   assign mapped = is_mapped(apb_req_in.paddr);
   assign wr = access & apb_req_in.pwrite & mapped;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_state.clk_prev = sel_clk;
      next_state.irq_pulse = 1'b0;

      // accumulator advances on each selected edge while enabled
      if (state.ctrl.enable && osc_edge) begin
         next_state.accum = sum[ACC_W-1:0];
      end

      // overflow raises the event and the sticky flag
      if (carry) begin
         next_state.irq_pulse = 1'b1;
      end

      // pending increment transfer counts osc edges; loads on the second
      if (state.load_pend && state.ctrl.enable && osc_edge) begin
         if (state.load_cnt == `NOA_LOAD_EDGES - 2'h1) begin
            next_state.inc_buf = state.inc_reg;
            next_state.load_pend = 1'b0;
            next_state.load_cnt = 2'h0;
         end else begin
            next_state.load_cnt = state.load_cnt + 2'h1;
         end
      end

      // read data is captured in the setup cycle, shown in the access cycle
      if (setup) begin
         unique case (apb_req_in.paddr)
            `NOA_OFS_CTRL: begin
               next_state.rdata = 32'h0000_0000;
               next_state.rdata[`NOA_CTRL_EN] = state.ctrl.enable;
               next_state.rdata[`NOA_CTRL_OUT] = out_level;
               next_state.rdata[`NOA_CTRL_POL] = state.ctrl.polarity;
               next_state.rdata[`NOA_CTRL_PFM] = state.ctrl.pfm;
            end
            `NOA_OFS_CLK: begin
               next_state.rdata = 32'h0000_0000;
               next_state.rdata[`NOA_CLK_PWS_LO +: 3] = state.ctrl.pulse_width;
               next_state.rdata[`NOA_CLK_CKS_LO +: 2] = state.ctrl.clk_sel;
            end
            `NOA_OFS_ACCL: next_state.rdata = get_byte(state.accum, 2'h0);
            `NOA_OFS_ACCH: next_state.rdata = get_byte(state.accum, 2'h1);
            `NOA_OFS_ACCU: next_state.rdata = get_byte(state.accum, 2'h2);
            `NOA_OFS_INCL: next_state.rdata = get_byte(state.inc_reg, 2'h0);
            `NOA_OFS_INCH: next_state.rdata = get_byte(state.inc_reg, 2'h1);
            `NOA_OFS_INCU: next_state.rdata = get_byte(state.inc_reg, 2'h2);
            `NOA_OFS_FLAG: next_state.rdata = {31'h0000_0000, state.irq_flag};
            default: next_state.rdata = 32'h0000_0000;
         endcase
      end

      // register writes take effect at the access edge
      if (wr) begin
         unique case (apb_req_in.paddr)
            `NOA_OFS_CTRL: begin
               next_state.ctrl.enable = apb_req_in.pwdata[`NOA_CTRL_EN];
               next_state.ctrl.polarity = apb_req_in.pwdata[`NOA_CTRL_POL];
               next_state.ctrl.pfm = apb_req_in.pwdata[`NOA_CTRL_PFM];
            end
            `NOA_OFS_CLK: begin
               next_state.ctrl.pulse_width = apb_req_in.pwdata[`NOA_CLK_PWS_LO +: 3];
               next_state.ctrl.clk_sel = apb_req_in.pwdata[`NOA_CLK_CKS_LO +: 2];
            end
            // software write to the accumulator beats a same-cycle addition
            `NOA_OFS_ACCL:
               next_state.accum = put_byte(state.accum, 2'h0, apb_req_in.pwdata[7:0]);
            `NOA_OFS_ACCH:
               next_state.accum = put_byte(state.accum, 2'h1, apb_req_in.pwdata[7:0]);
            `NOA_OFS_ACCU:
               next_state.accum = put_byte(state.accum, 2'h2, apb_req_in.pwdata[7:0]);
            `NOA_OFS_INCL: begin
               next_state.inc_reg = put_byte(state.inc_reg, 2'h0,
                                             apb_req_in.pwdata[7:0]);
               if (state.ctrl.enable) begin
                  // restart the two-edge wait; high and upper should be in place
                  next_state.load_pend = 1'b1;
                  next_state.load_cnt = 2'h0;
               end
            end
            `NOA_OFS_INCH:
               next_state.inc_reg = put_byte(state.inc_reg, 2'h1,
                                             apb_req_in.pwdata[7:0]);
            `NOA_OFS_INCU:
               next_state.inc_reg = put_byte(state.inc_reg, 2'h2,
                                             apb_req_in.pwdata[7:0]);
            `NOA_OFS_FLAG: begin
               // writing zero clears the flag
               if (!apb_req_in.pwdata[`NOA_FLAG_IRQ]) begin
                  next_state.irq_flag = 1'b0;
               end
            end
            default: begin
            end
         endcase
         // with the block stopped the buffers follow every increment write
         if (!state.ctrl.enable && is_inc_addr(apb_req_in.paddr)) begin
            next_state.inc_buf = next_state.inc_reg;
            next_state.load_pend = 1'b0;
            next_state.load_cnt = 2'h0;
         end
      end

      // an overflow in the clearing cycle still sets the flag
      if (carry) begin
         next_state.irq_flag = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // ------------------------------------------------------------
   // output stage
   // ------------------------------------------------------------
   noa_out_stage u_out_stage (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .osc_edge_in(osc_edge),
      .carry_in(carry),
      .ctrl_in(state.ctrl),
      .osc_out_out(out_level)
   );

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------

   // zero-wait slave: the answer comes in the first access cycle
   always_comb begin
      apb_rsp_out.prdata = state.rdata;
      apb_rsp_out.pready = access;
      apb_rsp_out.pslverr = access & ~mapped;
   end

   assign osc_out_out = out_level;
   assign osc_irq_event_out = state.irq_pulse;
   assign osc_irq_flag_out = state.irq_flag;

endmodule

`default_nettype wire

// file: sim/noa_src_model.sv
// model of the three candidate oscillator sources feeding the block
`timescale 1ns/1ps
`default_nettype none

module noa_src_model (
   // clock
   input wire logic core_clk_in,
   // control
   input wire logic run_in,
   // candidate source levels
   output logic [2:0] src_out
);
   logic [2:0] cnt [3];

   // half periods of 2, 3 and 4 cycles; parked low when stopped, so a stop gives no rising edge
   always_ff @(posedge core_clk_in) begin
      for (int k = 0; k < 3; k++) begin
         if (!run_in) begin
            cnt[k] <= 3'h0;
            src_out[k] <= 1'b0;
         end else if (cnt[k] == 3'(k + 1)) begin
            cnt[k] <= 3'h0;
            src_out[k] <= ~src_out[k];
         end else begin
            cnt[k] <= cnt[k] + 3'h1;
         end
      end
   end
endmodule

`default_nettype wire

// file: sim/noa_core_assertions.sv
// concurrent checks on the ports of the oscillator block
`timescale 1ns/1ps
`default_nettype none

`include "noa_cfg.svh"

module noa_chk #(
   parameter int ACC_W = 20
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // apb
   input wire noa_pkg::noa_apb_req_s apb_req_in,
   input wire noa_pkg::noa_apb_rsp_s apb_rsp_out,
   // sources
   input wire logic fast_internal_osc_in,
   input wire logic sys_osc_clk_in,
   input wire logic logic_cell_one_out_in,
   // results
   input wire logic osc_out_out,
   input wire logic osc_irq_event_out,
   input wire logic osc_irq_flag_out
);
   import noa_pkg::*;
   logic acc_now;
   logic flag_clr;
   logic mapped;
   logic en_q;
   logic pol_q;
   logic pfm_q;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);

   // access-phase decode
   assign acc_now = apb_req_in.psel && apb_req_in.penable;
   assign flag_clr = acc_now && apb_req_in.pwrite && apb_req_in.paddr == `NOA_OFS_FLAG
      && !apb_req_in.pwdata[`NOA_FLAG_IRQ];
   assign mapped = apb_req_in.paddr <= `NOA_OFS_FLAG && apb_req_in.paddr[1:0] == 2'h0;

   // shadow of the control bits, so that mode-dependent checks know the mode
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         en_q <= 1'b0;
         pol_q <= 1'b0;
         pfm_q <= 1'b0;
      end else if (acc_now && apb_req_in.pwrite && apb_req_in.paddr == `NOA_OFS_CTRL) begin
         en_q <= apb_req_in.pwdata[`NOA_CTRL_EN];
         pol_q <= apb_req_in.pwdata[`NOA_CTRL_POL];
         pfm_q <= apb_req_in.pwdata[`NOA_CTRL_PFM];
      end
   end

   sequence s_carry_seen;
      osc_irq_event_out && osc_irq_flag_out;
   endsequence
   // the toggle may land with the pulse or one cycle later
   sequence s_toggle_soon;
      ($changed(osc_out_out)) or (##1 $changed(osc_out_out));
   endsequence

   chk_ready_access: assert property (apb_rsp_out.pready == acc_now)
      else $error("pready differs from access phase");
   chk_slverr_map: assert property (acc_now |-> apb_rsp_out.pslverr == !mapped)
      else $error("pslverr wrong for address");
   chk_event_flag: assert property (osc_irq_event_out |->
      s_carry_seen ##1 !osc_irq_event_out)
      else $error("event without flag or longer than one cycle");
   chk_flag_cause: assert property ($rose(osc_irq_flag_out) |-> osc_irq_event_out)
      else $error("flag rose without overflow");
   chk_flag_hold: assert property (osc_irq_flag_out && !flag_clr |=> osc_irq_flag_out)
      else $error("flag dropped without clear");
   chk_fdc_toggle: assert property (en_q && !pfm_q && $stable({en_q, pfm_q, pol_q})
      && osc_irq_event_out |-> s_toggle_soon)
      else $error("no toggle on overflow");
   chk_idle_level: assert property (!en_q && $stable({en_q, pol_q}) |->
      osc_out_out == pol_q)
      else $error("idle output not polarity");
   chk_idle_quiet: assert property (!en_q && !$past(en_q) |-> !osc_irq_event_out)
      else $error("event while disabled");
endmodule

bind noa_core noa_chk #(.ACC_W(ACC_W)) noa_chk_u (
   .core_clk_in(core_clk_in),
   .sys_rst_in(sys_rst_in),
   .apb_req_in(apb_req_in),
   .apb_rsp_out(apb_rsp_out),
   .fast_internal_osc_in(fast_internal_osc_in),
   .sys_osc_clk_in(sys_osc_clk_in),
   .logic_cell_one_out_in(logic_cell_one_out_in),
   .osc_out_out(osc_out_out),
   .osc_irq_event_out(osc_irq_event_out),
   .osc_irq_flag_out(osc_irq_flag_out)
);

`default_nettype wire

// file: sim/numeric_oscillator_accumulator_bench.sv
// self-checking bench of the oscillator block over apb
`timescale 1ns/1ps
`default_nettype none

`include "noa_cfg.svh"

module numeric_oscillator_accumulator_bench;
   import noa_pkg::*;
   logic core_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic run = 1'b0;
   noa_apb_req_s req = '0;
   noa_apb_rsp_s rsp;
   logic [2:0] src;
   logic osc_out;
   logic irq_ev;
   logic irq_flag;
   logic out_q;
   logic src_q;
   logic slv;
   logic [1:0] sel = 2'h0;
   int err_count = 0;
   int samples_checked = 0;
   int edges = 0;
   int togs = 0;
   int evs = 0;
   int hi_run = 0;
   int hi_len = 0;
   int cyc = 0;
   int n;
   int t0;
   int v0;

   noa_core dut_u (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .apb_req_in(req),
      .apb_rsp_out(rsp), .fast_internal_osc_in(src[0]), .sys_osc_clk_in(src[1]),
      .logic_cell_one_out_in(src[2]), .osc_out_out(osc_out), .osc_irq_event_out(irq_ev),
      .osc_irq_flag_out(irq_flag));
   noa_src_model src_u (.core_clk_in(core_clk_in), .run_in(run), .src_out(src));

   always #5 core_clk_in = ~core_clk_in;

   // monitor: source edges, output toggles, events, length of last high pulse, timeout
   always @(posedge core_clk_in) begin
      src_q <= src[sel];
      out_q <= osc_out;
      cyc <= cyc + 1;
      if (src[sel] === 1'b1 && src_q === 1'b0) edges <= edges + 1;
      if (osc_out !== out_q) togs <= togs + 1;
      if (irq_ev === 1'b1) evs <= evs + 1;
      hi_run <= (osc_out === 1'b1) ? hi_run + 1 : 0;
      if (osc_out === 1'b0 && out_q === 1'b1) hi_len <= hi_run;
      if (cyc == 6000) begin
         err_count++;
         give_verdict();
      end
   end

   // --------------------------------------------------------
   // tasks
   // --------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge core_clk_in);
      req.penable <= 1'b1;
      do @(posedge core_clk_in); while (rsp.pready !== 1'b1);
      r = rsp.prdata;
      slv = rsp.pslverr;
      req <= '0;
      @(posedge core_clk_in);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      chk($sformatf("reg %h", a), r, exp);
   endtask

   task automatic acc_chk(input logic [19:0] v);
      rd(`NOA_OFS_ACCL, {24'h0, v[7:0]});
      rd(`NOA_OFS_ACCH, {24'h0, v[15:8]});
      rd(`NOA_OFS_ACCU, {28'h0, v[19:16]});
   endtask

   // zero the accumulator and load an increment, upper and high before low
   task automatic prep(input logic [19:0] inc);
      for (int k = 0; k < 3; k++) wr(8'(8 + 4 * k), 32'h0);
      wr(`NOA_OFS_INCU, {28'h0, inc[19:16]});
      wr(`NOA_OFS_INCH, {24'h0, inc[15:8]});
      wr(`NOA_OFS_INCL, {24'h0, inc[7:0]});
   endtask

   // let the sources run for a window, then stand still and settle
   task automatic go(input int len, output int cnt);
      int e0;
      e0 = edges;
      run <= 1'b1;
      repeat (len) @(posedge core_clk_in);
      run <= 1'b0;
      repeat (6) @(posedge core_clk_in);
      cnt = edges - e0;
   endtask

   task automatic give_verdict();
      if (err_count == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // --------------------------------------------------------
   // main sequence
   // --------------------------------------------------------
   initial begin
      repeat (16) @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      @(posedge core_clk_in);
      for (int i = 0; i < 9; i++) rd(8'(4 * i), 32'h0);
      rd(8'h24, 32'h0);
      chk("pslverr", {31'h0, slv}, 32'h1);
      for (int i = 0; i < 6; i++) wr(8'(8 + 4 * i), 32'(8'hA0 + i));
      for (int i = 0; i < 6; i++)
         rd(8'(8 + 4 * i), (i % 3 == 2) ? 32'(i) : 32'(8'hA0 + i));
      // fixed duty on each source: carries every fourth edge from zero
      for (int s = 0; s < 3; s++) begin
         prep(20'h40000);
         wr(`NOA_OFS_CLK, 32'(s));
         sel = 2'(s);
         wr(`NOA_OFS_CTRL, 32'h80);
         t0 = togs;
         v0 = evs;
         go(60, n);
         acc_chk(20'(n * 32'h40000));
         chk("toggles", 32'(togs - t0), 32'(n / 4));
         chk("events", 32'(evs - v0), 32'(n / 4));
         rd(`NOA_OFS_FLAG, 32'(n >= 4));
         wr(`NOA_OFS_FLAG, 32'h0);
         rd(`NOA_OFS_FLAG, 32'h0);
         wr(`NOA_OFS_CTRL, 32'h0);
      end
      // enabled reload: two more edges still add the old increment
      prep(20'h1);
      wr(`NOA_OFS_CTRL, 32'h80);
      wr(`NOA_OFS_INCL, 32'h10);
      go(40, n);
      acc_chk((n <= 2) ? 20'(n) : 20'(2 + (n - 2) * 16));
      wr(`NOA_OFS_CTRL, 32'h0);
      // pulse mode: pulse lasts 2^code source periods of 8 cycles
      for (int c = 0; c < 2; c++) begin
         prep(20'h40000);
         wr(`NOA_OFS_CLK, 32'((c << `NOA_CLK_PWS_LO) | 2));
         wr(`NOA_OFS_CTRL, 32'h81);
         go(140, n);
         chk("pulse width", 32'(hi_len), 32'(8 << c));
         wr(`NOA_OFS_CTRL, 32'h0);
      end
      wr(`NOA_OFS_CTRL, 32'h10);
      repeat (3) @(posedge core_clk_in);
      chk("inverted idle", {31'h0, osc_out}, 32'h1);
      give_verdict();
   end
endmodule

`default_nettype wire
